// *** core/mmd_addr_decode.sv ***
// Purpose: Translate one master's address into a target, bank and offset.
// Assumes: Combinational; one instance per master.
// Notes: Refused addresses yield MMD_T_NONE with err set.
`include "mmd_defines.svh"
module mmd_addr_decode
  import mmd_pkg::*;
#(
  parameter bit IS_CPU = 1'b0,
  parameter bit IS_USB = 1'b0,
  parameter bit EXT_OK = 1'b1
) (
  // Request
  input wire logic [31:0] addr,
  input wire logic we,
  input wire logic unmap,
  // Decode
  output mmd_tgt_e tgt,
  output logic [5:0] bank,
  output logic [22:0] offs,
  output logic err
);
  logic [23:0] ca; // Equivalent CPU byte address
  logic [23:0] rel; // Offset inside an external space
  logic ok; // Address lands in a master window
  logic [2:0] sp; // External space index

  // ****************************************
  // Master view to CPU view, then CPU map
  // ****************************************
  always_comb begin
    ca = addr[23:0];
    ok = 1'b1;
    sp = addr[26:24] - 3'h1;
    if (IS_CPU) begin
      ok = (addr[31:24] == 8'h00);
    end else if (addr >= `MMD_DUAL_OFS && addr <= `MMD_DUAL_TOP) begin
      ca = 24'(addr - `MMD_DUAL_OFS);
    end else if (addr >= `MMD_SING_LO && addr <= `MMD_SING_TOP) begin
      ca = 24'(addr - `MMD_SING_OFS);
    end else if (addr[31:27] == 5'h00 && addr[26:24] != 3'h0 && addr[26:24] <= 3'h5) begin
      // External windows step by 16 MB per space
      unique case (sp)
        3'h0: begin ca = `MMD_SING_END + addr[23:0]; ok = addr[23:0] < `MMD_SYNC_SIZE; end
        3'h1: begin ca = `MMD_CS2_BASE + addr[23:0]; ok = addr[23:0] < `MMD_CS2_SIZE; end
        3'h2: begin ca = `MMD_CS3_BASE + addr[23:0]; ok = addr[23:0] < `MMD_CS3_SIZE; end
        3'h3: begin ca = `MMD_CS4_BASE + addr[23:0]; ok = addr[23:0] < `MMD_CS45_SIZE; end
        default: begin ca = `MMD_CS5_BASE + addr[23:0]; ok = addr[23:0] < `MMD_CS5_SIZE; end
      endcase
      ok = ok & EXT_OK;
    end else begin
      ok = 1'b0;
    end
    tgt = MMD_T_NONE;
    bank = 6'h00;
    offs = 23'h000000;
    rel = 24'h000000;
    if (!ok) begin
      tgt = MMD_T_NONE; // Outside every window
    end else if (ca < `MMD_MMR_END) begin
      tgt = MMD_T_MMR;
      offs = {15'h0000, ca[7:0]};
    end else if (ca < `MMD_DUAL_END) begin
      tgt = MMD_T_DUAL;
      bank = {3'h0, ca[15:13]};
      offs = {10'h000, ca[12:0]};
    end else if (ca < `MMD_SING_END) begin
      tgt = MMD_T_SING;
      bank = {1'b0, ca[17:13] - 5'h08};
      offs = {10'h000, ca[12:0]};
    end else if (ca >= `MMD_ROM_BASE) begin
      // ROM range vanishes while unmapped
      tgt = (unmap || !IS_CPU || we) ? MMD_T_NONE : MMD_T_ROM;
      bank = {4'h0, ca[16:15]};
      offs = {8'h00, ca[14:0]};
    end else begin
      tgt = MMD_T_EXT;
      if (ca >= `MMD_CS5_BASE) begin
        bank = 6'h04;
        rel = ca - `MMD_CS5_BASE;
      end else if (ca >= `MMD_CS4_BASE) begin
        bank = 6'h03;
        rel = ca - `MMD_CS4_BASE;
      end else if (ca >= `MMD_CS3_BASE) begin
        bank = 6'h02;
        rel = ca - `MMD_CS3_BASE;
      end else if (ca >= `MMD_CS2_BASE) begin
        bank = 6'h01;
        rel = ca - `MMD_CS2_BASE;
      end else begin
        rel = ca - `MMD_SING_END;
      end
      offs = rel[22:0];
    end
    // USB never reaches the dual-access banks
    if (IS_USB && tgt == MMD_T_DUAL) begin
      tgt = MMD_T_NONE;
    end
    err = (tgt == MMD_T_NONE);
  end
endmodule : mmd_addr_decode

// *** core/mmd_decoder.sv ***
// Purpose: Memory map decoder and bank arbiter for a 16 MB unified space.
// Assumes: Masters 0 program bus, 1 data bus, 2..5 DMA 0..3, 6 USB.
// Notes: Routes are registered one cycle after the request is taken.
//
// What this block does
// - Decode one unified 16 MB byte space
// - Low 64 KB selects eight dual-access banks
// - Dual banks take two accesses per cycle
// - First 192 bytes are the register area
// - Next 256 KB selects 32 single banks
// - Single bank serves one access, others stall
// - Masters see dual RAM 0x10000 higher
// - Masters see single RAM 0x80000 higher
// - USB master never reaches dual RAM
// - Top 128 KB is four-bank zero-wait ROM
// - Only CPU buses reach the ROM
// - Unmap bit removes ROM, range left unmapped
// - Hardware reset clears unmap; software reset keeps
// - From 0x050000 upward is external memory
// - Sync space, then async spaces two to five
// - Master views of spaces step 16 MB
// - Mapped ROM shadows top of space five
// - Only fourth DMA reaches external memory
// - Sync space uses one or two selects
// - One select per async space during access
// - 16-bit bus, 8-bit async only, 21 address
// - NAND correction: 1-bit both, 4-bit 8-bit
`include "mmd_defines.svh"
module mmd_decoder
  import mmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic sw_reset,
  // Status word three, unmap field
  input wire logic unmap_wr,
  input wire logic unmap_wdata,
  output logic rom_unmap_select,
  // Master requests
  input wire logic [`MMD_NMST-1:0] mst_req,
  input wire logic [`MMD_NMST-1:0] mst_we,
  input wire logic [`MMD_NMST-1:0][31:0] mst_addr,
  output logic [`MMD_NMST-1:0] mst_stall,
  // Registered routes
  output logic [`MMD_NMST-1:0] rt_vld,
  output logic [`MMD_NMST-1:0] rt_err,
  output logic [`MMD_NMST-1:0] rt_we,
  output mmd_tgt_e [`MMD_NMST-1:0] rt_tgt,
  output logic [`MMD_NMST-1:0][5:0] rt_bank,
  output logic [`MMD_NMST-1:0][22:0] rt_offs,
  // External memory port configuration
  input wire logic ext_bus_8bit,
  input wire logic sync_pair_mode,
  input wire logic nand_mode,
  input wire logic ecc4_req,
  // External memory port selects
  output logic sync_space_select_a,
  output logic sync_space_select_b,
  output logic [3:0] async_space_selects,
  output logic [20:0] ext_addr,
  output logic [1:0] ecc_mode
);
  mmd_state_s q; // Registered state
  mmd_state_s d; // Next state
  mmd_tgt_e [`MMD_NMST-1:0] dec_tgt; // Decoded target
  logic [`MMD_NMST-1:0][5:0] dec_bank; // Decoded bank
  logic [`MMD_NMST-1:0][22:0] dec_offs; // Decoded offset
  logic [`MMD_NMST-1:0] dec_err; // Decoder refusal
  logic [`MMD_NMST-1:0] bad; // Any refusal
  logic [`MMD_NMST-1:0][5:0] key; // Shared resource id
  logic [`MMD_NMST-1:0] arb; // Takes part in arbitration
  logic [`MMD_NMST-1:0] stall; // Lost this cycle
  logic [`MMD_NMST-1:0] grant; // Taken this cycle

  // ****************************************
  // Per-master address decode
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `MMD_NMST; gi++) begin : g_dec
      mmd_addr_decode #(
        .IS_CPU(gi < 2),
        .IS_USB(gi == `MMD_USB_IDX),
        .EXT_OK(gi < 2 || gi >= `MMD_DMA_EXT_IDX)
      ) u_dec (
        .addr(mst_addr[gi]),
        .we(mst_we[gi]),
        .unmap(q.unmap),
        .tgt(dec_tgt[gi]),
        .bank(dec_bank[gi]),
        .offs(dec_offs[gi]),
        .err(dec_err[gi])
      );
    end
  endgenerate

  // ****************************************
  // Resource keys and refusals
  // ****************************************
  // Each shared bank or the external port gets one key
  always_comb begin
    for (int i = 0; i < `MMD_NMST; i++) begin
      // The sync space cannot run on the narrow bus
      bad[i] = dec_err[i] || (ext_bus_8bit && dec_tgt[i] == MMD_T_EXT && dec_bank[i] == 6'h00);
      arb[i] = mst_req[i] && !bad[i] && dec_tgt[i] != MMD_T_MMR;
      unique case (dec_tgt[i])
        MMD_T_DUAL: key[i] = dec_bank[i];
        MMD_T_SING: key[i] = `MMD_KEY_SING + dec_bank[i];
        MMD_T_ROM: key[i] = `MMD_KEY_ROM + dec_bank[i];
        default: key[i] = `MMD_KEY_EXT;
      endcase
    end
  end

  // ****************************************
  // Fixed-priority bank arbitration
  // ****************************************
  // Quadratic in masters, but seven masters keep it shallow
  always_comb begin
    logic [1:0] seen;
    seen = 2'h0;
    for (int i = 0; i < `MMD_NMST; i++) begin
      seen = 2'h0;
      for (int j = 0; j < i; j++) begin
        // Only higher-priority contenders count
        if (arb[j] && key[j] == key[i] && seen != 2'h3) begin
          seen = seen + 2'h1;
        end
      end
      if (!arb[i]) begin
        stall[i] = 1'b0;
      end else if (dec_tgt[i] == MMD_T_DUAL) begin
        stall[i] = (seen >= `MMD_DUAL_CAP);
      end else begin
        stall[i] = (seen != 2'h0);
      end
      grant[i] = mst_req[i] && !bad[i] && !stall[i];
    end
  end

  assign mst_stall = stall;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    // Software reset never touches the unmap bit
    if (unmap_wr) begin
      d.unmap = unmap_wdata;
    end
    d.vld = grant;
    d.err = mst_req & bad;
    d.we = mst_we & grant;
    d.cs_a = 1'b0;
    d.cs_b = 1'b0;
    d.cs_async = 4'h0;
    for (int i = 0; i < `MMD_NMST; i++) begin
      d.tgt[i] = grant[i] ? dec_tgt[i] : MMD_T_NONE;
      d.bank[i] = grant[i] ? dec_bank[i] : 6'h00;
      d.offs[i] = grant[i] ? dec_offs[i] : 23'h000000;
      // At most one master owns the external port per cycle
      if (grant[i] && dec_tgt[i] == MMD_T_EXT) begin
        if (dec_bank[i] == 6'h00) begin
          // Pair mode hands the upper half to the second select
          d.cs_b = sync_pair_mode && dec_offs[i][22];
          d.cs_a = !(sync_pair_mode && dec_offs[i][22]);
        end else begin
          d.cs_async[dec_bank[i][1:0] - 2'h1] = 1'b1;
        end
        // Word address on the wide bus, byte address on the narrow
        d.ext_addr = ext_bus_8bit ? dec_offs[i][20:0] : dec_offs[i][21:1];
      end
    end
    // 4-bit correction is offered on the narrow bus only
    if (!nand_mode) begin
      d.ecc = `MMD_ECC_NONE;
    end else if (ecc4_req && ext_bus_8bit) begin
      d.ecc = `MMD_ECC_4BIT;
    end else begin
      d.ecc = `MMD_ECC_1BIT;
    end
    // Software reset drops routes in flight but keeps the map
    if (sw_reset) begin
      d.vld = '0;
      d.err = '0;
      // Route details read as zero whenever no route stands
      d.we = '0;
      for (int i = 0; i < `MMD_NMST; i++) begin
        d.tgt[i] = MMD_T_NONE;
        d.bank[i] = 6'h00;
        d.offs[i] = 23'h000000;
      end
      d.cs_a = 1'b0;
      d.cs_b = 1'b0;
      d.cs_async = 4'h0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Hardware reset maps the ROM so the boot code runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rom_unmap_select = q.unmap;
  assign rt_vld = q.vld;
  assign rt_err = q.err;
  assign rt_we = q.we;
  assign rt_tgt = q.tgt;
  assign rt_bank = q.bank;
  assign rt_offs = q.offs;
  assign sync_space_select_a = q.cs_a;
  assign sync_space_select_b = q.cs_b;
  assign async_space_selects = q.cs_async;
  assign ext_addr = q.ext_addr;
  assign ecc_mode = q.ecc;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Helper: two routes on one single-access bank
  logic sing_clash;
  always_comb begin
    sing_clash = 1'b0;
    for (int i = 0; i < `MMD_NMST; i++) begin
      for (int j = 0; j < i; j++) begin
        if (q.vld[i] && q.vld[j] && q.tgt[i] == MMD_T_SING && q.tgt[j] == MMD_T_SING
            && q.bank[i] == q.bank[j]) begin
          sing_clash = 1'b1;
        end
      end
    end
  end

  a_sing_one: assert property (!sing_clash)
    else $error("two routes on one single bank");
  a_prog_first: assert property (!mst_stall[0])
    else $error("program bus stalled");
  a_dual_pair: assert property (mst_req[0] && mst_req[1] && !mst_we[0] && mst_addr[0][31:13] == 19'h00001
      && mst_addr[1][31:13] == 19'h00001 |-> ##1 rt_vld[0] && rt_vld[1] && rt_bank[0] == rt_bank[1])
    else $error("dual bank did not take two");
  a_usb_no_dual: assert property (rt_vld[`MMD_USB_IDX] |-> rt_tgt[`MMD_USB_IDX] != MMD_T_DUAL)
    else $error("usb reached dual bank");
  a_dma_no_rom: assert property (rt_vld[5:2] != 4'h0 |-> rt_tgt[2] != MMD_T_ROM && rt_tgt[3] != MMD_T_ROM
      && rt_tgt[4] != MMD_T_ROM && rt_tgt[5] != MMD_T_ROM)
    else $error("dma reached rom");
  a_dma_ext_only3: assert property (mst_req[2] && mst_addr[2][31:24] >= 8'h01 && mst_addr[2][31:24] <= 8'h05
      |=> rt_err[2])
    else $error("dma0 reached external space");
  a_unmap_keep: assert property (sw_reset && !unmap_wr |=> $stable(rom_unmap_select))
    else $error("software reset changed unmap");
  a_unmap_rom: assert property (rom_unmap_select && !unmap_wr && mst_req[1] && mst_addr[1] == 32'h00FE0000
      |=> rt_err[1] && !rt_vld[1])
    else $error("rom reachable while unmapped");
  a_rom_map: assert property (!rom_unmap_select && !mst_we[0] && mst_req[0] && mst_addr[0][31:15] == 17'h001FF
      |=> rt_vld[0] && rt_tgt[0] == MMD_T_ROM && rt_bank[0] == 6'h03)
    else $error("rom bank three not routed");
  a_dual_offset: assert property (mst_req[3] && mst_addr[3] == 32'h000100C0 && !mst_stall[3]
      |=> rt_tgt[3] == MMD_T_DUAL && rt_bank[3] == 6'h00 && rt_offs[3] == 23'h0000C0)
    else $error("dma dual offset wrong");
  a_sing_offset: assert property (mst_req[4] && mst_addr[4] == 32'h00090000 && !mst_stall[4]
      |=> rt_tgt[4] == MMD_T_SING && rt_bank[4] == 6'h00)
    else $error("dma single offset wrong");
  a_cs_onehot: assert property ($onehot0({sync_space_select_a, sync_space_select_b, async_space_selects}))
    else $error("more than one select");
  a_ecc_narrow: assert property (ecc_mode == `MMD_ECC_4BIT |-> $past(ext_bus_8bit))
    else $error("4-bit correction on wide bus");

  c_dual_double: cover property (rt_vld[0] && rt_vld[1] && rt_tgt[0] == MMD_T_DUAL && rt_bank[0] == rt_bank[1]);
  c_sing_stall: cover property (mst_stall[1] && mst_req[0]);
  c_rom_read: cover property (rt_vld[0] && rt_tgt[0] == MMD_T_ROM);
  c_async_cs: cover property (async_space_selects[3]);
endmodule : mmd_decoder

// *** core/mmd_defines.svh ***
// Purpose: Shared constants of the memory map decoder.
// Assumes: Byte addresses; 24-bit CPU view, 32-bit master view.
// Notes: Definitions only.
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH

// ****************************************
// Masters and arbitration
// ****************************************
`define MMD_NMST 7
`define MMD_USB_IDX 6
`define MMD_DMA_EXT_IDX 5
`define MMD_DUAL_CAP 2'h2
`define MMD_KEY_SING 6'h08
`define MMD_KEY_ROM 6'h28
`define MMD_KEY_EXT 6'h2C

// ****************************************
// CPU byte map
// ****************************************
`define MMD_MMR_END 24'h0000C0
`define MMD_DUAL_END 24'h010000
`define MMD_SING_END 24'h050000
`define MMD_CS2_BASE 24'h800000
`define MMD_CS3_BASE 24'hC00000
`define MMD_CS4_BASE 24'hE00000
`define MMD_CS5_BASE 24'hF00000
`define MMD_ROM_BASE 24'hFE0000

// ****************************************
// Master-side view
// ****************************************
`define MMD_DUAL_OFS 32'h00010000
`define MMD_DUAL_TOP 32'h0001FFFF
`define MMD_SING_OFS 32'h00080000
`define MMD_SING_LO 32'h00090000
`define MMD_SING_TOP 32'h000CFFFF
`define MMD_SYNC_SIZE 24'h7B0000
`define MMD_CS2_SIZE 24'h400000
`define MMD_CS3_SIZE 24'h200000
`define MMD_CS45_SIZE 24'h100000
`define MMD_CS5_SIZE 24'h0E0000

// ****************************************
// Error correction modes
// ****************************************
`define MMD_ECC_NONE 2'h0
`define MMD_ECC_1BIT 2'h1
`define MMD_ECC_4BIT 2'h2
`endif

// *** core/mmd_pkg.sv ***
// Purpose: Types of the memory map decoder.
// Assumes: mmd_defines.svh on the include path.
// Notes: Constants live in the header.
`include "mmd_defines.svh"
package mmd_pkg;
  // ****************************************
  // Route targets
  // ****************************************
  typedef enum logic [2:0] {
    MMD_T_NONE, MMD_T_MMR, MMD_T_DUAL, MMD_T_SING, MMD_T_ROM, MMD_T_EXT
  } mmd_tgt_e;

  // ****************************************
  // Whole decoder state
  // ****************************************
  typedef struct packed {
    logic unmap; // ROM unmap bit
    logic [`MMD_NMST-1:0] vld; // Routed access
    logic [`MMD_NMST-1:0] err; // Refused access
    logic [`MMD_NMST-1:0] we; // Routed write
    mmd_tgt_e [`MMD_NMST-1:0] tgt; // Routed target
    logic [`MMD_NMST-1:0][5:0] bank; // Bank or space
    logic [`MMD_NMST-1:0][22:0] offs; // Byte offset in target
    logic cs_a; // Sync select, first
    logic cs_b; // Sync select, second
    logic [3:0] cs_async; // Async spaces 2..5
    logic [20:0] ext_addr; // External address
    logic [1:0] ecc; // Active correction mode
  } mmd_state_s;
endpackage : mmd_pkg

// *** testbench/mmd_mst_model.sv ***
// Purpose: Bus master model that drives the decoder's request ports.
// Assumes: Bench loads a request set with a one-cycle go pulse.
// Notes: A stalled master holds; a taken master drops and scrambles.
`include "mmd_defines.svh"
module mmd_mst_model
  import mmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bench side
  input wire logic go,
  input wire logic [`MMD_NMST-1:0] ld_req,
  input wire logic [`MMD_NMST-1:0] ld_we,
  input wire logic [`MMD_NMST-1:0][31:0] ld_addr,
  // Decoder side
  input wire logic [`MMD_NMST-1:0] mst_stall,
  output logic [`MMD_NMST-1:0] mst_req,
  output logic [`MMD_NMST-1:0] mst_we,
  output logic [`MMD_NMST-1:0][31:0] mst_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Request holding
  // ****************************************
  // Released lines show the inverse, so a stale address never decodes by luck
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mst_req <= '0;
      mst_we <= '0;
      mst_addr <= '0;
    end else if (go) begin
      mst_req <= ld_req;
      mst_we <= ld_we;
      mst_addr <= ld_addr;
    end else begin
      for (int i = 0; i < `MMD_NMST; i++) begin
        // Taken this edge; a stalled one keeps everything
        if (mst_req[i] && !mst_stall[i]) begin
          mst_req[i] <= 1'b0;
          mst_we[i] <= ~mst_we[i];
          mst_addr[i] <= ~mst_addr[i];
        end
      end
    end
  end
endmodule : mmd_mst_model

// *** testbench/tb_mmd_decoder.sv ***
// Purpose: Self-checking bench of the memory map decoder.
// Assumes: Masters 0,1 CPU buses, 2..5 DMA 0..3, 6 USB.
// Notes: Routes are captured per master as they pulse.
`include "mmd_defines.svh"
module tb_mmd_decoder
  import mmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, nrst, sw_reset, unmap_wr, unmap_wdata, rom_unmap_select, go;
  logic [`MMD_NMST-1:0] mst_req, mst_we, mst_stall, rt_vld, rt_err, rt_we, ld_req, ld_we;
  logic [`MMD_NMST-1:0][31:0] mst_addr, ld_addr;
  mmd_tgt_e [`MMD_NMST-1:0] rt_tgt;
  logic [`MMD_NMST-1:0][5:0] rt_bank;
  logic [`MMD_NMST-1:0][22:0] rt_offs;
  logic ext_bus_8bit, sync_pair_mode, nand_mode, ecc4_req, sel_a, sel_b;
  logic [3:0] async_sel;
  logic [20:0] ext_addr;
  logic [1:0] ecc_mode;
  // Captured routes and the cycle each arrived in
  logic [`MMD_NMST-1:0] g_vld, g_err, g_we;
  mmd_tgt_e g_tgt [`MMD_NMST];
  logic [5:0] g_bank [`MMD_NMST];
  logic [22:0] g_offs [`MMD_NMST];
  logic [5:0] g_cs;
  int g_cyc [`MMD_NMST];
  int cyc, fails, n_compared;

  mmd_decoder uut (.clk(clk), .nrst(nrst), .sw_reset(sw_reset), .unmap_wr(unmap_wr),
    .unmap_wdata(unmap_wdata), .rom_unmap_select(rom_unmap_select), .mst_req(mst_req),
    .mst_we(mst_we), .mst_addr(mst_addr), .mst_stall(mst_stall), .rt_vld(rt_vld), .rt_err(rt_err),
    .rt_we(rt_we), .rt_tgt(rt_tgt), .rt_bank(rt_bank), .rt_offs(rt_offs), .ext_bus_8bit(ext_bus_8bit),
    .sync_pair_mode(sync_pair_mode), .nand_mode(nand_mode), .ecc4_req(ecc4_req),
    .sync_space_select_a(sel_a), .sync_space_select_b(sel_b), .async_space_selects(async_sel),
    .ext_addr(ext_addr), .ecc_mode(ecc_mode));
  mmd_mst_model mst (.clk(clk), .nrst(nrst), .go(go), .ld_req(ld_req), .ld_we(ld_we),
    .ld_addr(ld_addr), .mst_stall(mst_stall), .mst_req(mst_req), .mst_we(mst_we), .mst_addr(mst_addr));

  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Route outputs last one cycle, so latch each pulse
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < `MMD_NMST; i++) begin
      if (rt_vld[i] || rt_err[i]) begin
        g_vld[i] = rt_vld[i];
        g_err[i] = rt_err[i];
        g_we[i] = rt_we[i];
        g_tgt[i] = rt_tgt[i];
        g_bank[i] = rt_bank[i];
        g_offs[i] = rt_offs[i];
        g_cyc[i] = cyc;
      end
    end
    if (sel_a || sel_b || async_sel != 4'h0) begin
      g_cs = {sel_a, sel_b, async_sel};
    end
  end
  // The whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    end_sim();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Hand the loaded set to the masters and wait until all are taken
  task automatic launch();
    int k;
    g_vld = '0;
    g_err = '0;
    g_cs = '0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 20 && mst_req !== '0; k++) @(posedge clk);
    if (k == 20) begin
      chk(mst_req, '0, "hung request");
    end
    repeat (3) @(posedge clk);
  endtask : launch
  // One request; bank 3F skips bank and offset
  task automatic do1(input int m, input logic [31:0] a, input logic w, input mmd_tgt_e t,
      input logic [5:0] b, input logic [22:0] o, input logic e, input logic [5:0] cs);
    ld_req <= `MMD_NMST'(1) << m;
    ld_we <= `MMD_NMST'(w) << m;
    ld_addr[m] <= a;
    launch();
    chk(g_err[m], e, "err");
    chk(g_vld[m], !e, "vld");
    chk(g_we[m], w & !e, "we");
    chk(g_tgt[m], e ? MMD_T_NONE : t, "tgt");
    chk(g_cs, cs, "selects");
    if (b != 6'h3F) begin
      chk(g_bank[m], b, "bank");
      chk(g_offs[m], o, "offs");
    end
  endtask : do1
  // Two masters at once; d is the expected gap in cycles
  task automatic pair(input int m0, input logic [31:0] a0, input int m1, input logic [31:0] a1, input int d);
    ld_req <= (`MMD_NMST'(1) << m0) | (`MMD_NMST'(1) << m1);
    ld_we <= '0;
    ld_addr[m0] <= a0;
    ld_addr[m1] <= a1;
    launch();
    chk(g_vld[m0] & g_vld[m1], 1'b1, "both taken");
    chk(32'(g_cyc[m1] - g_cyc[m0]), 32'(d), "gap");
  endtask : pair
  task automatic pulse_unmap(input logic v);
    unmap_wr <= 1'b1;
    unmap_wdata <= v;
    @(posedge clk);
    unmap_wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_unmap
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {nrst, sw_reset, unmap_wr, unmap_wdata, go, ld_req, ld_we, ld_addr} = '0;
    {ext_bus_8bit, sync_pair_mode, nand_mode, ecc4_req} = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(rom_unmap_select, 1'b0, "unmap at reset");
    // CPU view of the whole map
    do1(0, 32'h00000010, 1'b0, MMD_T_MMR, 6'h3F, 23'h0, 1'b0, 6'h00);
    do1(1, 32'h000000C0, 1'b1, MMD_T_DUAL, 6'h00, 23'h0000C0, 1'b0, 6'h00);
    do1(0, 32'h0000FFFF, 1'b0, MMD_T_DUAL, 6'h07, 23'h001FFF, 1'b0, 6'h00);
    do1(0, 32'h00010000, 1'b1, MMD_T_SING, 6'h00, 23'h000000, 1'b0, 6'h00);
    do1(1, 32'h0004FFFF, 1'b0, MMD_T_SING, 6'h1F, 23'h001FFF, 1'b0, 6'h00);
    do1(0, 32'h00050000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h20);
    do1(1, 32'h00800002, 1'b1, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h01);
    chk(ext_addr, 21'h000001, "word address");
    do1(0, 32'h00C00000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h02);
    do1(0, 32'h00E00000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h04);
    do1(0, 32'h00FDFFFF, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h08);
    do1(0, 32'h00FE0000, 1'b0, MMD_T_ROM, 6'h00, 23'h0, 1'b0, 6'h00);
    do1(0, 32'h00FFFFFF, 1'b0, MMD_T_ROM, 6'h03, 23'h007FFF, 1'b0, 6'h00);
    do1(1, 32'h00FE0000, 1'b1, MMD_T_ROM, 6'h3F, 23'h0, 1'b1, 6'h00);
    $display("test cpu map done");
    // Master views and access limits
    do1(3, 32'h000100C0, 1'b0, MMD_T_DUAL, 6'h00, 23'h0000C0, 1'b0, 6'h00);
    do1(4, 32'h00090000, 1'b1, MMD_T_SING, 6'h00, 23'h000000, 1'b0, 6'h00);
    do1(6, 32'h000100C0, 1'b0, MMD_T_DUAL, 6'h3F, 23'h0, 1'b1, 6'h00);
    do1(6, 32'h000CE000, 1'b0, MMD_T_SING, 6'h1F, 23'h000000, 1'b0, 6'h00);
    do1(5, 32'h01000000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h20);
    do1(5, 32'h02000000, 1'b1, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h01);
    do1(5, 32'h05000000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h08);
    do1(2, 32'h02000000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b1, 6'h00);
    do1(4, 32'h01000000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b1, 6'h00);
    $display("test master views done");
    // Bank sharing and priority
    pair(0, 32'h00010000, 1, 32'h00010002, 1);
    pair(1, 32'h00012000, 4, 32'h00092000, 1);
    pair(0, 32'h00010000, 1, 32'h00012000, 0);
    pair(0, 32'h00FE0000, 1, 32'h00FE0002, 1);
    pair(0, 32'h00FE0000, 1, 32'h00FE8000, 0);
    ld_req <= `MMD_NMST'(7);
    ld_addr[0] <= 32'h00002000;
    ld_addr[1] <= 32'h00002002;
    ld_addr[2] <= 32'h00012004;
    launch();
    chk(32'(g_cyc[1] - g_cyc[0]), 32'h0, "dual pair");
    chk(32'(g_cyc[2] - g_cyc[0]), 32'h1, "dual third");
    $display("test conflicts done");
    // ROM removal across both kinds of reset
    pulse_unmap(1'b1);
    chk(rom_unmap_select, 1'b1, "unmap set");
    do1(1, 32'h00FE0000, 1'b0, MMD_T_ROM, 6'h3F, 23'h0, 1'b1, 6'h00);
    do1(0, 32'h00FDFFFE, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h08);
    sw_reset <= 1'b1;
    @(posedge clk);
    sw_reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk(rom_unmap_select, 1'b1, "unmap after soft reset");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(rom_unmap_select, 1'b0, "unmap after hard reset");
    do1(1, 32'h00FE8000, 1'b0, MMD_T_ROM, 6'h01, 23'h0, 1'b0, 6'h00);
    pulse_unmap(1'b0);
    $display("test unmap done");
    // External port configuration
    sync_pair_mode <= 1'b1;
    do1(0, 32'h00450000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h10);
    do1(0, 32'h00050000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h20);
    ext_bus_8bit <= 1'b1;
    do1(0, 32'h00050000, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b1, 6'h00);
    do1(0, 32'h00800002, 1'b0, MMD_T_EXT, 6'h3F, 23'h0, 1'b0, 6'h01);
    chk(ext_addr, 21'h000002, "byte address");
    nand_mode <= 1'b1;
    ecc4_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk(ecc_mode, `MMD_ECC_4BIT, "ecc 8-bit");
    ext_bus_8bit <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ecc_mode, `MMD_ECC_1BIT, "ecc 16-bit");
    ecc4_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ecc_mode, `MMD_ECC_1BIT, "ecc one");
    nand_mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk(ecc_mode, `MMD_ECC_NONE, "ecc off");
    $display("test external port done");
    end_sim();
  end
endmodule : tb_mmd_decoder
